/* hdl/twos_complement_arith_unit.sv */
// sixteen-bit twos-complement arithmetic and shift datapath with registered results
`timescale 1ns/1ps
module twos_complement_arith_unit #(
  parameter int WORD_W = arith_pkg::WORD_W
) (
  input wire logic CLK, // processor clock, 250 MHz
  input wire logic RST, // asynchronous reset, active high
  input wire logic CE, // clock enable, freezes all state when low
  input wire logic START, // request strobe, one operation per high cycle
  input wire logic [2:0] OP, // operation code
  input wire logic [15:0] OPERAND_A, // first operand word
  input wire logic [15:0] OPERAND_B, // second operand word
  input wire logic [15:0] INSTR, // instruction word holding the displacement
  output logic [15:0] RESULT, // result word, low half of a product
  output logic [15:0] RESULT_HI, // high half of a product, sign fill otherwise
  output logic OVERFLOW, // signed overflow of the last operation
  output logic CARRY, // carry out of the last operation if an add, subtract or negate, else zero
  output logic ZERO, // result word is zero
  output logic NEGATIVE, // result word sign bit
  output logic HI_EXACT, // high half alone is a correct value
  output logic DONE // one-cycle pulse, results updated
);

  logic [15:0] add_a;
  logic [15:0] add_b;
  logic add_cin;
  logic [15:0] add_sum;
  logic add_cout;
  logic add_ovf;
  logic is_add;
  logic is_sub;
  logic is_neg;
  logic arith_op;
  logic [15:0] disp_ext;
  logic [15:0] byte_ext;
  logic [15:0] shl_val;
  logic [15:0] shr_val;
  logic shl_ovf;
  logic signed [31:0] product;
  logic mul_ovf;
  logic [15:0] next_result;
  logic [15:0] next_result_hi;
  logic next_overflow;
  logic next_carry;
  logic take;

  assign take = START && CE;
  assign is_add = (OP == arith_pkg::OP_ADD);
  assign is_sub = (OP == arith_pkg::OP_SUB);
  assign is_neg = (OP == arith_pkg::OP_NEG);
  assign arith_op = is_add || is_sub || is_neg;

  // negate and subtract share the adder: invert, then carry in one
  assign add_a = is_neg ? ~OPERAND_A : OPERAND_A;
  assign add_b = is_neg ? arith_pkg::WORD_ZERO : (is_sub ? ~OPERAND_B : OPERAND_B);
  assign add_cin = is_sub || is_neg;

  word_adder #(
    .W(WORD_W)
  ) u_adder (
    .a(add_a),
    .b(add_b),
    .cin(add_cin),
    .sum(add_sum),
    .cout(add_cout),
    .ovf(add_ovf)
  );

  // displacement field is the low nine bits; its top bit is the sign
  assign disp_ext = {{(16 - arith_pkg::DISP_W){INSTR[arith_pkg::DISP_SIGN_POS]}},
                     INSTR[arith_pkg::DISP_W-1:0]};
  assign byte_ext = {{(16 - arith_pkg::BYTE_W){OPERAND_A[arith_pkg::BYTE_W-1]}},
                     OPERAND_A[arith_pkg::BYTE_W-1:0]};

  assign shl_val = {OPERAND_A[14:0], 1'b0};
  assign shl_ovf = OPERAND_A[15] ^ OPERAND_A[14];
  assign shr_val = {OPERAND_A[arith_pkg::WORD_SIGN_POS], OPERAND_A[15:1]};

  // one-cycle signed multiply; timing is tight at 250 MHz but keeps the unit single-latency
  assign product = $signed(OPERAND_A) * $signed(OPERAND_B);
  assign mul_ovf = (product[31:16] != {16{product[15]}});

  assign next_result =
    arith_op ? add_sum :
    (OP == arith_pkg::OP_EXT_DISP) ? disp_ext :
    (OP == arith_pkg::OP_EXT_BYTE) ? byte_ext :
    (OP == arith_pkg::OP_SHL) ? shl_val :
    (OP == arith_pkg::OP_SHR) ? shr_val :
    product[15:0];

  // outside a multiply the high half carries the sign fill of the result
  assign next_result_hi = (OP == arith_pkg::OP_MUL) ? product[31:16] : {16{next_result[15]}};

  // negating the most negative word overflows through the adder itself
  assign next_overflow =
    arith_op ? add_ovf :
    (OP == arith_pkg::OP_SHL) ? shl_ovf :
    (OP == arith_pkg::OP_MUL) ? mul_ovf :
    1'b0;

  assign next_carry = arith_op ? add_cout : 1'b0;

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      RESULT <= arith_pkg::RESULT_RST;
      RESULT_HI <= arith_pkg::RESULT_HI_RST;
      OVERFLOW <= arith_pkg::OVERFLOW_RST;
      CARRY <= arith_pkg::CARRY_RST;
      ZERO <= arith_pkg::ZERO_RST;
      NEGATIVE <= arith_pkg::NEGATIVE_RST;
      HI_EXACT <= arith_pkg::HI_EXACT_RST;
      DONE <= arith_pkg::DONE_RST;
    end
    else if (CE)
    begin
      DONE <= START;
      if (START)
      begin
        RESULT <= next_result;
        RESULT_HI <= next_result_hi;
        OVERFLOW <= next_overflow;
        CARRY <= next_carry;
        ZERO <= (next_result == arith_pkg::WORD_ZERO);
        NEGATIVE <= next_result[arith_pkg::WORD_SIGN_POS];
        HI_EXACT <= (next_result == arith_pkg::WORD_ZERO);
      end
    end
  end

  // helper values for the checks below
  logic [15:0] add_ref;
  logic add_ovf_ref;
  logic [31:0] mul_ref;

  assign add_ref = OPERAND_A + OPERAND_B;
  assign add_ovf_ref = (OPERAND_A[15] == OPERAND_B[15]) && (add_ref[15] != OPERAND_A[15]);
  assign mul_ref = 32'($signed(OPERAND_A) * $signed(OPERAND_B));

  property p_sign_flag;
    @(posedge CLK) disable iff (RST)
    NEGATIVE == RESULT[15];
  endproperty
  a_sign_flag: assert property (p_sign_flag) else $error("sign flag differs from result top bit");

  property p_word_sign;
    @(posedge CLK) disable iff (RST)
    // a signed difference below zero shows as sign bit set unless it wrapped through overflow
    take && (OP == arith_pkg::OP_SUB) && ($signed(OPERAND_A) < $signed(OPERAND_B)) |=> NEGATIVE != OVERFLOW;
  endproperty
  a_word_sign: assert property (p_word_sign) else $error("borrowing subtract left sign clear");

  property p_negate;
    @(posedge CLK) disable iff (RST)
    take && is_neg |=> RESULT == (~$past(OPERAND_A) + arith_pkg::WORD_ONE) && DONE;
  endproperty
  a_negate: assert property (p_negate) else $error("negate is not invert plus one");

  property p_disp_ext;
    @(posedge CLK) disable iff (RST)
    take && (OP == arith_pkg::OP_EXT_DISP) |=>
      RESULT == {{7{$past(INSTR[8])}}, $past(INSTR[8:0])} && RESULT_HI == {16{$past(INSTR[8])}};
  endproperty
  a_disp_ext: assert property (p_disp_ext) else $error("displacement widened wrongly");

  property p_byte_ext;
    @(posedge CLK) disable iff (RST)
    take && (OP == arith_pkg::OP_EXT_BYTE) |=>
      RESULT[15:8] == {8{$past(OPERAND_A[7])}} && RESULT[7:0] == $past(OPERAND_A[7:0]);
  endproperty
  a_byte_ext: assert property (p_byte_ext) else $error("byte not filled with its sign");

  property p_add;
    @(posedge CLK) disable iff (RST)
    take && is_add |=> RESULT == $past(add_ref) && CARRY == ($past(add_ref) < $past(OPERAND_A));
  endproperty
  a_add: assert property (p_add) else $error("unsigned sum or carry wrong");

  property p_add_ovf;
    @(posedge CLK) disable iff (RST)
    take && is_add |=> OVERFLOW == $past(add_ovf_ref);
  endproperty
  a_add_ovf: assert property (p_add_ovf) else $error("signed add overflow wrong");

  property p_zero_neg;
    @(posedge CLK) disable iff (RST)
    take && is_neg && (OPERAND_A == arith_pkg::WORD_ZERO) |=> ZERO && !NEGATIVE && !OVERFLOW;
  endproperty
  a_zero_neg: assert property (p_zero_neg) else $error("negated zero is not plain zero");

  property p_most_neg;
    @(posedge CLK) disable iff (RST)
    take && is_neg && (OPERAND_A == arith_pkg::MOST_NEG) |=> OVERFLOW && RESULT == arith_pkg::MOST_NEG;
  endproperty
  a_most_neg: assert property (p_most_neg) else $error("most negative negation not flagged");

  property p_shl;
    @(posedge CLK) disable iff (RST)
    take && (OP == arith_pkg::OP_SHL) |=>
      RESULT == {$past(OPERAND_A[14:0]), 1'b0} && OVERFLOW == (RESULT[15] != $past(OPERAND_A[15]));
  endproperty
  a_shl: assert property (p_shl) else $error("left shift or lost-bit flag wrong");

  property p_shr;
    @(posedge CLK) disable iff (RST)
    take && (OP == arith_pkg::OP_SHR) |=>
      RESULT == {$past(OPERAND_A[15]), $past(OPERAND_A[15:1])} && !OVERFLOW;
  endproperty
  a_shr: assert property (p_shr) else $error("right shift did not copy the sign");

  property p_mul;
    @(posedge CLK) disable iff (RST)
    take && (OP == arith_pkg::OP_MUL) |=>
      {RESULT_HI, RESULT} == $past(mul_ref) && HI_EXACT == (RESULT == arith_pkg::WORD_ZERO);
  endproperty
  a_mul: assert property (p_mul) else $error("double-length product wrong");

  property p_hold;
    @(posedge CLK) disable iff (RST)
    // with the clock enable low the done pulse is frozen, so only an enabled idle cycle must clear it
    !take |=> $stable(OVERFLOW) && (!$past(CE) || !DONE);
  endproperty
  a_hold: assert property (p_hold) else $error("overflow changed without an operation");

  property p_done;
    @(posedge CLK) disable iff (RST)
    take |=> DONE ##1 (!$past(CE) || $past(START) || !DONE);
  endproperty
  a_done: assert property (p_done) else $error("done pulse missing or stretched");

  property p_c_most_neg;
    @(posedge CLK) disable iff (RST)
    take && is_neg && (OPERAND_A == arith_pkg::MOST_NEG);
  endproperty
  c_most_neg: cover property (p_c_most_neg);

  property p_c_add_ovf;
    @(posedge CLK) disable iff (RST)
    take && is_add ##1 OVERFLOW;
  endproperty
  c_add_ovf: cover property (p_c_add_ovf);

  property p_c_mul_inexact;
    @(posedge CLK) disable iff (RST)
    take && (OP == arith_pkg::OP_MUL) ##1 !HI_EXACT && RESULT_HI[15];
  endproperty
  c_mul_inexact: cover property (p_c_mul_inexact);

  property p_c_shl_lost;
    @(posedge CLK) disable iff (RST)
    take && (OP == arith_pkg::OP_SHL) ##1 OVERFLOW;
  endproperty
  c_shl_lost: cover property (p_c_shl_lost);

endmodule

/* pkg/arith_pkg.sv */
// shared constants and operation codes for the twos-complement arithmetic unit
package arith_pkg;

  localparam int WORD_W = 16;
  localparam int DISP_W = 9;
  localparam int BYTE_W = 8;
  localparam int PROD_W = 2 * WORD_W;

  // bit index of the displacement sign inside the instruction word (printed bit 8 of 1..16)
  localparam int DISP_SIGN_POS = 8;
  // bit index of the word sign (printed bit 1 of 1..16)
  localparam int WORD_SIGN_POS = 15;

  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [15:0] WORD_ONE = 16'h0001;
  localparam logic [15:0] MOST_NEG = 16'h8000;

  // reset values of the registered outputs
  localparam logic [15:0] RESULT_RST = 16'h0000;
  localparam logic [15:0] RESULT_HI_RST = 16'h0000;
  localparam logic OVERFLOW_RST = 1'b0;
  localparam logic CARRY_RST = 1'b0;
  localparam logic DONE_RST = 1'b0;
  localparam logic ZERO_RST = 1'b1;
  localparam logic NEGATIVE_RST = 1'b0;
  localparam logic HI_EXACT_RST = 1'b1;

  // cycles from an accepted request to its answer
  localparam int LATENCY_CYC = 1;

  localparam int OP_W = 3;
  localparam logic [2:0] OP_ADD = 3'h0;
  localparam logic [2:0] OP_SUB = 3'h1;
  localparam logic [2:0] OP_NEG = 3'h2;
  localparam logic [2:0] OP_EXT_DISP = 3'h3;
  localparam logic [2:0] OP_EXT_BYTE = 3'h4;
  localparam logic [2:0] OP_SHL = 3'h5;
  localparam logic [2:0] OP_SHR = 3'h6;
  localparam logic [2:0] OP_MUL = 3'h7;

endpackage

/* hdl/word_adder.sv */
// unsigned word adder with carry out and signed overflow
`timescale 1ns/1ps
module word_adder #(
  parameter int W = 16
) (
  input wire logic [W-1:0] a, // first addend
  input wire logic [W-1:0] b, // second addend
  input wire logic cin, // carry in
  output logic [W-1:0] sum, // low W bits of the sum
  output logic cout, // carry out of the top bit
  output logic ovf // signed result does not fit
);

  logic [W:0] full;

  // the sign bit is just the top magnitude bit here
  assign full = {1'b0, a} + {1'b0, b} + {{W{1'b0}}, cin};
  assign sum = full[W-1:0];
  assign cout = full[W];
  // same-signed inputs giving a differently signed sum
  assign ovf = (a[W-1] == b[W-1]) && (sum[W-1] != a[W-1]);

endmodule

/* verification/seq_model.sv */
// sequencer model that presents requests to the arithmetic unit
`timescale 1ns/1ps
module seq_model (
  input wire logic clk, // processor clock
  output logic ce, // clock enable
  output logic start, // request strobe
  output logic [2:0] op, // operation code
  output logic [15:0] a, // first operand
  output logic [15:0] b, // second operand
  output logic [15:0] instr // instruction word
);
  initial
  begin
    ce = 1'b1;
    start = 1'b0;
    op = 3'h0;
    a = 16'h0;
    b = 16'h0;
    instr = 16'h0;
  end
  // idle operands show the inverse of the last ones so a stale value never looks valid
  task automatic issue(input logic [2:0] o, input logic [15:0] x, y, w, input logic hold, en);
    @(posedge clk);
    ce <= en;
    start <= 1'b1;
    op <= o;
    a <= x;
    b <= y;
    instr <= w;
    if (!hold)
    begin
      @(posedge clk);
      ce <= 1'b1;
      start <= 1'b0;
      a <= ~x;
      b <= ~y;
      instr <= ~w;
    end
  endtask
endmodule

/* verification/twos_complement_arith_unit_test.sv */
// self-checking bench for the twos-complement arithmetic unit
`timescale 1ns/1ps
module twos_complement_arith_unit_test;
  typedef struct packed {logic [15:0] r; logic [15:0] h; logic v; logic c;} exp_t;
  logic CLK, RST, CE, START, OVERFLOW, CARRY, ZERO, NEGATIVE, HI_EXACT, DONE;
  logic [2:0] OP;
  logic [15:0] OPERAND_A, OPERAND_B, INSTR, RESULT, RESULT_HI;
  logic [31:0] seed = 32'h3227;
  int n_mismatch = 0;
  int checks = 0;
  int cycles = 0;
  exp_t last;

  seq_model i_seq_model (.clk(CLK), .ce(CE), .start(START), .op(OP), .a(OPERAND_A), .b(OPERAND_B), .instr(INSTR));

  twos_complement_arith_unit i_twos_complement_arith_unit (.CLK(CLK), .RST(RST), .CE(CE), .START(START), .OP(OP),
    .OPERAND_A(OPERAND_A), .OPERAND_B(OPERAND_B), .INSTR(INSTR), .RESULT(RESULT), .RESULT_HI(RESULT_HI),
    .OVERFLOW(OVERFLOW), .CARRY(CARRY), .ZERO(ZERO), .NEGATIVE(NEGATIVE), .HI_EXACT(HI_EXACT), .DONE(DONE));

  initial
  begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // add, subtract and negate share one unsigned adder: x + y + carry in
  function automatic exp_t model(input logic [2:0] o, input logic [15:0] a, b, w);
    logic [15:0] x;
    logic [15:0] y;
    logic [16:0] s;
    logic signed [31:0] p;
    exp_t e;
    x = (o == arith_pkg::OP_NEG) ? ~a : a;
    y = (o == arith_pkg::OP_ADD) ? b : (o == arith_pkg::OP_SUB) ? ~b : 16'h0;
    s = {1'b0, x} + {1'b0, y} + {16'h0, o != arith_pkg::OP_ADD};
    p = $signed(a) * $signed(b);
    e = '0;
    case (o)
      arith_pkg::OP_EXT_DISP: e.r = {{7{w[8]}}, w[8:0]};
      arith_pkg::OP_EXT_BYTE: e.r = {{8{a[7]}}, a[7:0]};
      arith_pkg::OP_SHL: e.r = {a[14:0], 1'b0};
      arith_pkg::OP_SHR: e.r = {a[15], a[15:1]};
      arith_pkg::OP_MUL: e.r = p[15:0];
      default: e.r = s[15:0];
    endcase
    e.c = (o <= arith_pkg::OP_NEG) & s[16];
    e.v = (o <= arith_pkg::OP_NEG) ? (x[15] == y[15]) && (s[15] != x[15]) : (o == arith_pkg::OP_SHL) ? a[15] ^ a[14]
        : (o == arith_pkg::OP_MUL) && (p[31:15] != {17{p[15]}});
    e.h = (o == arith_pkg::OP_MUL) ? p[31:16] : {16{e.r[15]}};
    return e;
  endfunction

  task automatic cmp(input string what, input logic [15:0] want, got);
    checks++;
    if (got !== want)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, want, got);
    end
  endtask

  task automatic verify(input exp_t e, input logic d);
    cmp("RESULT", e.r, RESULT);
    cmp("RESULT_HI", e.h, RESULT_HI);
    cmp("OVERFLOW", 16'(e.v), 16'(OVERFLOW));
    cmp("CARRY", 16'(e.c), 16'(CARRY));
    cmp("ZERO", 16'(e.r == 16'h0), 16'(ZERO));
    cmp("NEGATIVE", 16'(e.r[15]), 16'(NEGATIVE));
    cmp("HI_EXACT", 16'(e.r == 16'h0), 16'(HI_EXACT));
    cmp("DONE", 16'(d), 16'(DONE));
  endtask

  // one operation, then one idle cycle in which every status must hold and DONE must clear
  task automatic run(input logic [2:0] o, input logic [15:0] x, y, w);
    i_seq_model.issue(o, x, y, w, 1'b0, 1'b1);
    #1;
    last = model(o, x, y, w);
    verify(last, 1'b1);
    @(posedge CLK);
    #1;
    verify(last, 1'b0);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  always @(posedge CLK)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_mismatch++;
      results();
    end
  end

  initial
  begin
    logic [31:0] r;
    logic [31:0] q;
    RST = 1'b1;
    repeat (16) @(posedge CLK);
    RST <= 1'b0;
    #1;
    verify('0, 1'b0);
    $display("test reset done");
    run(arith_pkg::OP_ADD, 16'h7fff, 16'h0001, 16'h0);
    run(arith_pkg::OP_ADD, 16'hff53, 16'h00ad, 16'h0);
    run(arith_pkg::OP_SUB, 16'h8000, 16'h0001, 16'h0);
    run(arith_pkg::OP_SUB, 16'h0001, 16'h0002, 16'h0);
    run(arith_pkg::OP_NEG, 16'h0000, 16'h0, 16'h0);
    run(arith_pkg::OP_NEG, 16'h8000, 16'h0, 16'h0);
    run(arith_pkg::OP_NEG, 16'h00ad, 16'h0, 16'h0);
    run(arith_pkg::OP_EXT_DISP, 16'h0, 16'h0, 16'hfead);
    run(arith_pkg::OP_EXT_DISP, 16'h0, 16'h0, 16'h0353);
    run(arith_pkg::OP_EXT_BYTE, 16'h1280, 16'h0, 16'h0);
    run(arith_pkg::OP_SHL, 16'h4000, 16'h0, 16'h0);
    run(arith_pkg::OP_SHL, 16'hc001, 16'h0, 16'h0);
    run(arith_pkg::OP_SHR, 16'h8001, 16'h0, 16'h0);
    run(arith_pkg::OP_MUL, 16'hffff, 16'h0002, 16'h0);
    run(arith_pkg::OP_MUL, 16'h0100, 16'h0100, 16'h0);
    $display("test corners done");
    i_seq_model.issue(arith_pkg::OP_NEG, 16'h8000, 16'h0, 16'h0, 1'b1, 1'b1);
    i_seq_model.issue(arith_pkg::OP_ADD, 16'h0001, 16'h0001, 16'h0, 1'b1, 1'b1);
    #1;
    verify(model(arith_pkg::OP_NEG, 16'h8000, 16'h0, 16'h0), 1'b1);
    run(arith_pkg::OP_ADD, 16'h0001, 16'h0001, 16'h0);
    $display("test back to back done");
    i_seq_model.issue(arith_pkg::OP_NEG, 16'h0001, 16'h0, 16'h0, 1'b0, 1'b0);
    #1;
    verify(last, 1'b0);
    $display("test clock enable done");
    repeat (150)
    begin
      r = rnd();
      q = rnd();
      run(r[2:0], r[31:16], q[15:0], q[31:16]);
    end
    $display("test random done");
    results();
  end
endmodule
